/* File: logic/ars_pkg.sv */
// Shared constants and types for the antenna reconfiguration sequencer
package ars_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 200;
	localparam int DBNC_TIME_US  = 1000;
	localparam int DBNC_CYCLES   = DBNC_TIME_US * CLK_MHZ;

	// ------------------------------------------------------------
	// Site geometry
	// ------------------------------------------------------------
	localparam int NUM_CH        = 10;
	localparam int NUM_REFL      = 16;
	localparam int NUM_DIR       = 8;
	localparam int TUNE_W        = NUM_CH + 1;	// Top bit is the all-around element
	localparam int CH_MID_FIRST  = 4;
	localparam int CH_HIGH_FIRST = 8;
	localparam logic [4:0] REFL_FOUR  = 5'h04;
	localparam logic [4:0] REFL_SIX   = 5'h06;
	localparam logic [4:0] REFL_EIGHT = 5'h08;
	localparam logic [3:0] REFL_OPPOSITE = 4'h8;

	// ------------------------------------------------------------
	// Synchronised input vector layout
	// ------------------------------------------------------------
	localparam int IN_BAND_LO = 0;
	localparam int IN_BAND_HI = 1;
	localparam int IN_CH      = 2;
	localparam int IN_WIDE    = 12;
	localparam int IN_NARROW  = 13;
	localparam int IN_BOMNI   = 14;
	localparam int IN_DIR     = 15;
	localparam int IN_DOMNI   = 23;
	localparam int IN_START   = 24;
	localparam int IN_XMIT    = 25;
	localparam int IN_RF_OK   = 26;
	localparam int IN_TUNED   = 27;
	localparam int IN_RDONE   = 29;
	localparam int IN_SWR     = 31;
	localparam int IN_ARST    = 33;
	localparam int IN_W       = 34;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_SETUP  = 12'h008;
	localparam int CTRL_LOCK    = 0;
	localparam int CTRL_ARC_CLR = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_HALT} ars_state_t;
	typedef enum logic [1:0] {BEAM_OMNI, BEAM_WIDE, BEAM_NARROW} ars_beam_t;

endpackage

/* File: logic/ars_sync_if.sv */
// Raw and cleaned switch vector between the sequencer and its input filter
`timescale 1ns/1ps
`default_nettype none
interface ars_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface
`default_nettype wire

/* File: logic/ars_debounce.sv */
// Two-flop synchroniser and shared-timer debouncer for a switch vector
`timescale 1ns/1ps
`default_nettype none
module ars_debounce #(
	parameter int CYCLES = 2
) (
	input  wire logic  i_ref_clk,
	input  wire logic  i_rstn,
	ars_sync_if.filt   sif
);
	localparam int W  = $bits(sif.raw);
	localparam int CW = $clog2(CYCLES + 1);

	initial begin
		if (CYCLES < 1) $error("debounce length must be at least one cycle");
	end

	logic [W-1:0]  meta_reg;
	logic [W-1:0]  sync_reg;
	logic [W-1:0]  last_reg;
	logic [W-1:0]  clean_reg;
	logic [CW-1:0] cnt_reg;

	// ------------------------------------------------------------
	// Synchroniser: first stage feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= sif.raw;
			sync_reg <= meta_reg;
		end
	end

	// Vector must hold still for the full count before it is passed on
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			last_reg  <= '0;
			clean_reg <= '0;
			cnt_reg   <= '0;
		end else if (sync_reg != last_reg) begin
			last_reg <= sync_reg;
			cnt_reg  <= '0;
		end else if (cnt_reg == CW'(CYCLES - 1)) begin
			clean_reg <= last_reg;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign sif.clean = clean_reg;
endmodule
`default_nettype wire

/* File: logic/ars_sequencer.sv */
// Antenna reconfiguration sequencer with panel inputs and an APB slave
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - First configuration-changing command lights the pending lamp.
// - RF switch follows programmed band before start; mechanisms stay still.
// - After start, ignore frequency and direction commands until done.
// - Start connects stored commands to tuner and valve outputs.
// - Light matching busy and reflector busy according to changes in progress.
// - Clear each busy lamp independently on its own completion.
// - Both busy clear: drop pending, light done, re-enable entry.
// - In transmit, ignore pushbuttons but keep setting lamps lit.
// - Transmit during a change halts it; restart needs change and start (the code restarts from halt on start alone).
// - Translate band, beam and bearing, channel into switch, reflectors, tuner.
// - Unused band goes all-off and all-around; complete only when all succeed.
// - Beamwidth gives reflector count four, six or eight; bearing picks which.
// - Activating a reflector opens its valve; deactivating closes it.
// - Each band drives sixteen reflector valves and one matching unit.
// - Close the selected vacuum switch, open all the others.
// - Arc fault when standing wave ratio exceeds two to one.
// - Arc fault opens the transmitter interlock.
// - Band commands act only while entry is permitted.
// - All-around beam deactivates every reflector of the active group.
// - Interlock open whenever the completion signal is absent.
module ars_sequencer #(
	parameter int DBNC_CYCLES = ars_pkg::DBNC_CYCLES
) (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_rstn,
	input  wire logic                        i_band_lo_btn,
	input  wire logic                        i_band_hi_btn,
	input  wire logic [ars_pkg::NUM_CH-1:0]  i_channel_btn,
	input  wire logic                        i_wide_btn,
	input  wire logic                        i_narrow_btn,
	input  wire logic                        i_beam_omni_btn,
	input  wire logic [ars_pkg::NUM_DIR-1:0] i_bearing_btn,
	input  wire logic                        i_bearing_omni_btn,
	input  wire logic                        i_start_btn,
	input  wire logic                        i_transmit_sel,
	input  wire logic                        i_rf_interlock,
	input  wire logic [1:0]                  i_match_tuned,
	input  wire logic [1:0]                  i_refl_done,
	input  wire logic [1:0]                  i_swr_over,
	input  wire logic                        i_alarm_reset,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic [31:0]                      prdata,
	output logic                             o_rf_band_hi,
	output logic [ars_pkg::NUM_REFL-1:0]     o_valve_lo,
	output logic [ars_pkg::NUM_REFL-1:0]     o_valve_hi,
	output logic [ars_pkg::TUNE_W-1:0]       o_tune_lo,
	output logic [ars_pkg::TUNE_W-1:0]       o_tune_hi,
	output logic                             o_actuate_en,
	output logic                             o_pending_lamp,
	output logic                             o_done_lamp,
	output logic                             o_tune_busy_lamp,
	output logic                             o_reflector_busy_lamp,
	output logic                             o_entry_permit_lamp,
	output logic                             o_arc_lamp,
	output logic                             o_xmtr_interlock,
	output logic [1:0]                       o_band_lamp,
	output logic [ars_pkg::NUM_CH-1:0]       o_channel_lamp,
	output logic [2:0]                       o_beam_lamp,
	output logic [ars_pkg::NUM_DIR-1:0]      o_bearing_lamp
);
	localparam int NR = ars_pkg::NUM_REFL;
	localparam int NC = ars_pkg::NUM_CH;
	localparam int TW = ars_pkg::TUNE_W;

	// ------------------------------------------------------------
	// Input filtering
	// ------------------------------------------------------------
	ars_sync_if #(.W(ars_pkg::IN_W)) sif ();

	// Every panel and site input enters through the synchroniser and debouncer; the APB pins do not
	assign sif.raw = {i_alarm_reset, i_swr_over, i_refl_done, i_match_tuned,
		i_rf_interlock, i_transmit_sel, i_start_btn, i_bearing_omni_btn,
		i_bearing_btn, i_beam_omni_btn, i_narrow_btn, i_wide_btn,
		i_channel_btn, i_band_hi_btn, i_band_lo_btn};

	ars_debounce #(.CYCLES(DBNC_CYCLES)) u_dbnc (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.sif       (sif)
	);

	logic [ars_pkg::IN_W-1:0] in_c;
	logic [ars_pkg::IN_W-1:0] prev_reg;
	logic [ars_pkg::IN_W-1:0] rise;

	assign in_c = sif.clean;
	assign rise = in_c & ~prev_reg;

	// Previous cleaned vector for press detection
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= in_c;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Reflector count from beamwidth and channel range
	function automatic logic [4:0] refl_count(input logic [3:0] ch, input logic narrow);
		if (ch >= 4'(ars_pkg::CH_HIGH_FIRST)) begin
			return narrow ? ars_pkg::REFL_EIGHT : ars_pkg::REFL_SIX;
		end else if (ch >= 4'(ars_pkg::CH_MID_FIRST)) begin
			return narrow ? ars_pkg::REFL_EIGHT : ars_pkg::REFL_FOUR;
		end else begin
			return narrow ? ars_pkg::REFL_SIX : ars_pkg::REFL_FOUR;
		end
	endfunction

	// Contiguous block of reflectors on the side opposite the bearing
	function automatic logic [NR-1:0] refl_mask(input logic [2:0] brg, input logic [4:0] n);
		logic [NR-1:0] m;
		logic [3:0]    ctr;
		logic [3:0]    off;
		m   = '0;
		ctr = {brg, 1'b0} + ars_pkg::REFL_OPPOSITE;
		for (int k = 0; k < NR; k++) begin
			off  = 4'(k) - ctr + n[4:1];
			m[k] = ({1'b0, off} < n);
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Programmed setup
	// ------------------------------------------------------------
	ars_pkg::ars_state_t state_reg;
	ars_pkg::ars_beam_t  beam_reg;
	logic        band_hi_reg;
	logic [3:0]  ch_reg;
	logic [2:0]  brg_reg;
	logic        permit;
	logic        lock_reg;
	logic        cmd_ok;
	logic        band_cmd;
	logic        ch_cmd;
	logic        beam_cmd;
	logic        brg_cmd;
	logic        start_ok;
	logic        chg;
	logic [3:0]  ch_pick;
	logic [2:0]  brg_pick;

	assign permit   = ~in_c[ars_pkg::IN_XMIT];
	assign cmd_ok   = permit && !lock_reg && !start_ok
		&& (state_reg == ars_pkg::ST_IDLE || state_reg == ars_pkg::ST_ARMED);
	assign start_ok = rise[ars_pkg::IN_START] && permit && !lock_reg
		&& (state_reg == ars_pkg::ST_ARMED || state_reg == ars_pkg::ST_HALT);
	assign band_cmd = cmd_ok && |rise[ars_pkg::IN_BAND_HI:ars_pkg::IN_BAND_LO];
	assign ch_cmd   = cmd_ok && |rise[ars_pkg::IN_CH +: NC];
	assign beam_cmd = cmd_ok && |rise[ars_pkg::IN_BOMNI:ars_pkg::IN_WIDE];
	assign brg_cmd  = cmd_ok && |rise[ars_pkg::IN_DOMNI:ars_pkg::IN_DIR];

	// Lowest pressed channel and bearing button wins
	always_comb begin
		ch_pick  = ch_reg;
		brg_pick = brg_reg;
		for (int k = NC - 1; k >= 0; k--) begin
			if (rise[ars_pkg::IN_CH + k]) ch_pick = 4'(k);
		end
		for (int k = ars_pkg::NUM_DIR - 1; k >= 0; k--) begin
			if (rise[ars_pkg::IN_DIR + k]) brg_pick = 3'(k);
		end
	end

	// A band, channel or bearing command that alters the setup, or any beam command, calls for a new configuration
	assign chg = (band_cmd && (rise[ars_pkg::IN_BAND_HI] != band_hi_reg))
		|| (ch_cmd && ch_pick != ch_reg)
		|| (brg_cmd && rise[ars_pkg::IN_DOMNI] && beam_reg != ars_pkg::BEAM_OMNI)
		|| (brg_cmd && !rise[ars_pkg::IN_DOMNI] && brg_pick != brg_reg)
		|| beam_cmd;

	// Stored commands; the RF band is taken straight to the switch
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			band_hi_reg <= 1'b0;
			ch_reg      <= '0;
			brg_reg     <= '0;
			beam_reg    <= ars_pkg::BEAM_OMNI;
		end else begin
			if (band_cmd) band_hi_reg <= rise[ars_pkg::IN_BAND_HI];
			if (ch_cmd) ch_reg <= ch_pick;
			if (brg_cmd && !rise[ars_pkg::IN_DOMNI]) brg_reg <= brg_pick;
			if (brg_cmd && rise[ars_pkg::IN_DOMNI]) beam_reg <= ars_pkg::BEAM_OMNI;
			else if (beam_cmd && rise[ars_pkg::IN_WIDE]) beam_reg <= ars_pkg::BEAM_WIDE;
			else if (beam_cmd && rise[ars_pkg::IN_NARROW]) beam_reg <= ars_pkg::BEAM_NARROW;
			else if (beam_cmd) beam_reg <= ars_pkg::BEAM_OMNI;
		end
	end

	// ------------------------------------------------------------
	// Target configuration
	// ------------------------------------------------------------
	logic [NR-1:0] tgt_mask;
	logic [TW-1:0] tgt_tune;
	logic [TW-1:0] omni_tune;

	assign tgt_mask  = (beam_reg == ars_pkg::BEAM_OMNI) ? '0
		: refl_mask(brg_reg, refl_count(ch_reg, beam_reg == ars_pkg::BEAM_NARROW));
	assign tgt_tune  = TW'(1) << ch_reg;
	assign omni_tune = TW'(1) << NC;

	// ------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------
	logic [NR-1:0] valve_lo_reg;
	logic [NR-1:0] valve_hi_reg;
	logic [TW-1:0] tune_lo_reg;
	logic [TW-1:0] tune_hi_reg;
	logic          applied_hi_reg;
	logic          pend_reg;
	logic          done_reg;
	logic          tbusy_reg;
	logic          rbusy_reg;
	logic          tuned_rise;
	logic          rdone_rise;
	logic          all_ok;
	logic [NR-1:0] new_lo;
	logic [NR-1:0] new_hi;
	logic [TW-1:0] new_tlo;
	logic [TW-1:0] new_thi;

	assign new_lo  = band_hi_reg ? '0 : tgt_mask;
	assign new_hi  = band_hi_reg ? tgt_mask : '0;
	assign new_tlo = band_hi_reg ? omni_tune : tgt_tune;
	assign new_thi = band_hi_reg ? tgt_tune : omni_tune;
	assign tuned_rise = rise[ars_pkg::IN_TUNED + 32'(applied_hi_reg)];
	assign rdone_rise = rise[ars_pkg::IN_RDONE + 32'(applied_hi_reg)];
	// Both groups finished and the RF switch confirmed its position
	assign all_ok = &in_c[ars_pkg::IN_TUNED +: 2] && &in_c[ars_pkg::IN_RDONE +: 2]
		&& in_c[ars_pkg::IN_RF_OK];

	// Main sequence: armed, running, halted
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ars_pkg::ST_IDLE;
			pend_reg  <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			case (state_reg)
				ars_pkg::ST_IDLE, ars_pkg::ST_ARMED: begin
					if (start_ok) begin
						state_reg <= ars_pkg::ST_RUN;
					end else if (chg) begin
						state_reg <= ars_pkg::ST_ARMED;
						pend_reg  <= 1'b1;
						done_reg  <= 1'b0;
					end
				end
				ars_pkg::ST_RUN: begin
					if (!permit) begin
						state_reg <= ars_pkg::ST_HALT;
					end else if (!tbusy_reg && !rbusy_reg && all_ok) begin
						state_reg <= ars_pkg::ST_IDLE;
						pend_reg  <= 1'b0;
						done_reg  <= 1'b1;
					end
				end
				ars_pkg::ST_HALT: begin
					if (start_ok) state_reg <= ars_pkg::ST_RUN;
				end
				default: state_reg <= ars_pkg::ST_IDLE;
			endcase
		end
	end

	// Outputs to the mechanisms change only when a change is started
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			valve_lo_reg   <= '0;
			valve_hi_reg   <= '0;
			tune_lo_reg    <= '0;
			tune_hi_reg    <= '0;
			applied_hi_reg <= 1'b0;
		end else if (start_ok && state_reg == ars_pkg::ST_ARMED) begin
			valve_lo_reg   <= new_lo;
			valve_hi_reg   <= new_hi;
			tune_lo_reg    <= new_tlo;
			tune_hi_reg    <= new_thi;
			applied_hi_reg <= band_hi_reg;
		end
	end

	// Busy lamps: set for the parts that really change, cleared apart
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tbusy_reg <= 1'b0;
			rbusy_reg <= 1'b0;
		end else if (start_ok && state_reg == ars_pkg::ST_ARMED) begin
			tbusy_reg <= (new_tlo != tune_lo_reg) || (new_thi != tune_hi_reg);
			rbusy_reg <= (new_lo != valve_lo_reg) || (new_hi != valve_hi_reg);
		end else if (state_reg == ars_pkg::ST_RUN) begin
			if (tuned_rise) tbusy_reg <= 1'b0;
			if (rdone_rise) rbusy_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Arc protection
	// ------------------------------------------------------------
	logic arc_reg;
	logic arc_clr;

	// A new arc in the clearing cycle keeps the latch set
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			arc_reg <= 1'b0;
		end else if (|in_c[ars_pkg::IN_SWR +: 2]) begin
			arc_reg <= 1'b1;
		end else if (arc_clr || in_c[ars_pkg::IN_ARST]) begin
			arc_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	logic        wr_acc;
	logic        mapped;
	logic [31:0] rd_next;
	logic        err_reg;

	assign wr_acc  = psel && penable && pwrite;
	assign mapped  = (paddr == ars_pkg::ADDR_CTRL) || (paddr == ars_pkg::ADDR_STATUS)
		|| (paddr == ars_pkg::ADDR_SETUP);
	assign arc_clr = wr_acc && paddr == ars_pkg::ADDR_CTRL && pwdata[ars_pkg::CTRL_ARC_CLR];
	assign pready  = 1'b1;
	assign pslverr = psel && penable && err_reg;

	// Read mux
	always_comb begin
		rd_next = '0;
		if (paddr == ars_pkg::ADDR_CTRL) begin
			rd_next[ars_pkg::CTRL_LOCK] = lock_reg;
		end else if (paddr == ars_pkg::ADDR_STATUS) begin
			rd_next[11:0] = {state_reg, o_xmtr_interlock, permit, arc_reg,
				rbusy_reg, tbusy_reg, done_reg, pend_reg, band_hi_reg, 2'h0};
		end else if (paddr == ars_pkg::ADDR_SETUP) begin
			rd_next[11:0] = {beam_reg, brg_reg, ch_reg, band_hi_reg, 2'h0};
		end
	end

	// Read data and error are captured in the setup cycle
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			prdata  <= '0;
			err_reg <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? '0 : rd_next;
			err_reg <= !mapped;
		end
	end

	// Control register write
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lock_reg <= ars_pkg::CTRL_RESET[ars_pkg::CTRL_LOCK];
		end else if (wr_acc && paddr == ars_pkg::ADDR_CTRL) begin
			lock_reg <= pwdata[ars_pkg::CTRL_LOCK];
		end
	end

	// ------------------------------------------------------------
	// Output drive
	// ------------------------------------------------------------
	assign o_rf_band_hi          = band_hi_reg;
	assign o_valve_lo            = valve_lo_reg;
	assign o_valve_hi            = valve_hi_reg;
	assign o_tune_lo             = tune_lo_reg;
	assign o_tune_hi             = tune_hi_reg;
	assign o_actuate_en          = (state_reg == ars_pkg::ST_RUN);
	assign o_pending_lamp        = pend_reg;
	assign o_done_lamp           = done_reg;
	assign o_tune_busy_lamp      = tbusy_reg;
	assign o_reflector_busy_lamp = rbusy_reg;
	assign o_entry_permit_lamp   = permit;
	assign o_arc_lamp            = arc_reg;
	assign o_xmtr_interlock      = !permit && !arc_reg && done_reg;
	// Setting lamps stay lit in transmit
	assign o_band_lamp    = {band_hi_reg, !band_hi_reg};
	assign o_channel_lamp = NC'(1) << ch_reg;
	assign o_beam_lamp    = 3'(1) << beam_reg;
	assign o_bearing_lamp = (beam_reg == ars_pkg::BEAM_OMNI) ? '0
		: ars_pkg::NUM_DIR'(1) << brg_reg;
endmodule
`default_nettype wire

/* File: bench/ars_monitor.sv */
// Concurrent checks on the sequencer lamp and actuator outputs
`timescale 1ns/1ps
`default_nettype none
module ars_monitor (
	input wire logic        i_ref_clk,
	input wire logic        i_rstn,
	input wire logic        o_actuate_en,
	input wire logic        o_pending_lamp,
	input wire logic        o_done_lamp,
	input wire logic        o_tune_busy_lamp,
	input wire logic        o_reflector_busy_lamp,
	input wire logic        o_entry_permit_lamp,
	input wire logic        o_arc_lamp,
	input wire logic        o_xmtr_interlock,
	input wire logic        o_rf_band_hi,
	input wire logic [15:0] o_valve_lo,
	input wire logic [15:0] o_valve_hi,
	input wire logic [10:0] o_tune_lo,
	input wire logic [10:0] o_tune_hi
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	// Steps of a finishing change
	sequence s_finish;
		$rose(o_done_lamp);
	endsequence
	sequence s_settled;
		!o_tune_busy_lamp && !o_reflector_busy_lamp && !o_pending_lamp && !o_actuate_en;
	endsequence
	// Output relations
	finish_clean_a: assert property (s_finish |-> s_settled)
		else $error("done lamp lit before settling");
	valve_hold_a: assert property (
		$changed({o_valve_lo, o_valve_hi, o_tune_lo, o_tune_hi}) |-> $rose(o_actuate_en))
		else $error("mechanism outputs moved without start");
	refl_count_a: assert property (($countones(o_valve_lo) inside {0, 4, 6, 8})
		&& ($countones(o_valve_hi) inside {0, 4, 6, 8})) else $error("bad reflector count");
	unused_off_a: assert property (o_actuate_en |->
		(o_rf_band_hi ? {o_valve_lo, o_tune_lo} : {o_valve_hi, o_tune_hi}) == 27'h0000400)
		else $error("unused group not parked");
	tune_onehot_a: assert property ($onehot0(o_tune_lo) && $onehot0(o_tune_hi))
		else $error("more than one vacuum switch closed");
	busy_pending_a: assert property (
		o_tune_busy_lamp || o_reflector_busy_lamp |-> o_pending_lamp) else $error("busy alone");
	interlock_gate_a: assert property (o_xmtr_interlock |->
		o_done_lamp && !o_arc_lamp && !o_entry_permit_lamp) else $error("interlock closed");
	start_pending_a: assert property ($rose(o_actuate_en) |->
		o_pending_lamp && !o_done_lamp && o_entry_permit_lamp) else $error("bad start");
endmodule
bind ars_sequencer ars_monitor i_mon (.i_ref_clk, .i_rstn, .o_actuate_en, .o_pending_lamp,
	.o_done_lamp, .o_tune_busy_lamp, .o_reflector_busy_lamp, .o_entry_permit_lamp, .o_arc_lamp,
	.o_xmtr_interlock, .o_rf_band_hi, .o_valve_lo, .o_valve_hi, .o_tune_lo, .o_tune_hi);
`default_nettype wire

/* File: bench/ars_site_model.sv */
// Remote site model: RF transfer switch, matching units and reflector controllers
`timescale 1ns/1ps
`default_nettype none
module ars_site_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_actuate_en,
	input  wire logic       i_band_hi,
	input  wire logic [7:0] i_tune_dly,
	input  wire logic [7:0] i_refl_dly,
	output logic            o_interlock,
	output logic [1:0]      o_tuned,
	output logic [1:0]      o_refl_done
);
	logic [7:0] rf_cnt;
	logic [8:0] run_cnt;
	logic       band_q;
	// Switch opens its interlock on a band move, closes it once transferred
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rf_cnt <= 8'h00;
			band_q <= 1'b0;
			o_interlock <= 1'b0;
		end else begin
			band_q <= i_band_hi;
			rf_cnt <= (band_q != i_band_hi) ? 8'h00 : rf_cnt + {7'h00, rf_cnt < 8'h0a};
			o_interlock <= (band_q == i_band_hi) && (rf_cnt == 8'h0a);
		end
	end
	// Units settle after their own delays while driven; both groups report
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_cnt <= 9'h000;
			o_tuned <= 2'h0;
			o_refl_done <= 2'h0;
		end else begin
			run_cnt <= i_actuate_en ? run_cnt + {8'h00, run_cnt != 9'h1ff} : 9'h000;
			o_tuned <= {2{i_actuate_en && (run_cnt >= {1'b0, i_tune_dly})}};
			o_refl_done <= {2{i_actuate_en && (run_cnt >= {1'b0, i_refl_dly})}};
		end
	end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the antenna reconfiguration sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, rstn, xmit, arst, intl, psel, penable, pwrite, pready, pslverr, err;
	logic        bhi, act, pend, done, tb, rb, arc, xil;
	logic [24:0] pb;
	logic [1:0]  swr, tnd, rdn, bl;
	logic [2:0]  bml;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] vlo, vhi;
	logic [10:0] tlo, thi;
	logic [9:0]  chl;
	logic [7:0]  tdly, rdly, brl;
	int          mismatches, num_checks, band, ch, bm, br;
	int          hist[$];
	ars_sequencer #(.DBNC_CYCLES(4)) i_dut (.i_ref_clk(clk), .i_rstn(rstn),
		.i_band_lo_btn(pb[0]), .i_band_hi_btn(pb[1]), .i_channel_btn(pb[11:2]),
		.i_wide_btn(pb[12]), .i_narrow_btn(pb[13]), .i_beam_omni_btn(pb[14]),
		.i_bearing_btn(pb[22:15]), .i_bearing_omni_btn(pb[23]), .i_start_btn(pb[24]),
		.i_transmit_sel(xmit), .i_rf_interlock(intl), .i_match_tuned(tnd), .i_refl_done(rdn),
		.i_swr_over(swr), .i_alarm_reset(arst), .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .o_rf_band_hi(bhi), .o_valve_lo(vlo), .o_valve_hi(vhi),
		.o_tune_lo(tlo), .o_tune_hi(thi), .o_actuate_en(act), .o_pending_lamp(pend),
		.o_done_lamp(done), .o_tune_busy_lamp(tb), .o_reflector_busy_lamp(rb),
		.o_entry_permit_lamp(), .o_arc_lamp(arc), .o_xmtr_interlock(xil), .o_band_lamp(bl),
		.o_channel_lamp(chl), .o_beam_lamp(bml), .o_bearing_lamp(brl));
	ars_site_model i_site (.i_ref_clk(clk), .i_rstn(rstn), .i_actuate_en(act), .i_band_hi(bhi),
		.i_tune_dly(tdly), .i_refl_dly(rdly), .o_interlock(intl), .o_tuned(tnd), .o_refl_done(rdn));
	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic press(input int k);
		pb[k] <= 1'b1;
		cyc(16);
		pb[k] <= 1'b0;
		cyc(16);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// Reference reflector pattern: contiguous block opposite the bearing
	function automatic logic [15:0] refl_exp(input int c, input int m, input int b);
		int n;
		logic [15:0] v;
		v = 16'h0000;
		n = (m == 1) ? ((c >= ars_pkg::CH_HIGH_FIRST) ? 6 : 4) : ((c < ars_pkg::CH_MID_FIRST) ? 6 : 8);
		for (int i = 0; i < n; i++) v[(2 * b + 8 - n / 2 + i) % 16] = 1'b1;
		return (m == 0) ? 16'h0000 : v;
	endfunction
	// One programmed change, optionally halted by transmit and restarted
	task automatic run(input bit halt);
		hist.push_back(ch);
		press(band);
		press(2 + ch);
		press((bm == 0) ? 23 : 15 + br);
		press((bm == 0) ? 14 : 11 + bm);
		chk("pending", pend, 1);
		chk("rf band", bhi, band);
		chk("idle actuate", act, 0);
		press(24);
		chk("actuate", act, 1);
		chk("valves", band ? vhi : vlo, refl_exp(ch, bm, br));
		chk("unused valves", band ? vlo : vhi, 0);
		chk("tune", band ? thi : tlo, 1 << ch);
		chk("unused tune", band ? tlo : thi, 11'h400);
		chk("busy", tb | rb, 1);
		press(2 + (ch + 1) % 10);
		chk("channel hold", chl, 1 << hist[$]);
		if (halt) begin
			xmit <= 1'b1;
			cyc(16);
			chk("halt", act, 0);
			press(2 + (ch + 2) % 10);
			chk("xmit lamps", chl, 1 << hist[$]);
			chk("set lamps", {bl, bml, brl}, {2'(1 << band), 3'(1 << bm), 8'(1 << br)});
			xmit <= 1'b0;
			cyc(16);
			chk("halt hold", act, 0);
			press(24);
		end
		for (int i = 0; i < 800 && done !== 1'b1; i++) cyc(1);
		chk("done", done, 1);
		chk("pending clear", pend, 0);
		chk("busy clear", {tb, rb}, 0);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{rstn, pb, xmit, swr, arst, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(32'hc2ff962e));
		cyc(5);
		rstn <= 1'b1;
		cyc(20);
		for (int r = 0; r < 6; r++) begin
			band = r % 2;
			ch = $urandom % 10;
			bm = (r == 4) ? 0 : 1 + r % 2;
			br = $urandom % 8;
			tdly <= 8'd80 + 8'($urandom % 120);
			rdly <= 8'd80 + 8'($urandom % 120);
			run(r == 2);
			$display("test change %0d done", r);
		end
		apb(0, ars_pkg::ADDR_STATUS, 0);
		chk("status", rd[4:3], 2'b10);
		apb(0, ars_pkg::ADDR_SETUP, 0);
		chk("setup", rd[11:2], {2'(bm), 3'(br), 4'(ch), 1'(band)});
		apb(0, 12'h0f0, 0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		apb(1, ars_pkg::ADDR_CTRL, 32'h1);
		press(2 + (ch + 3) % 10);
		chk("lock", pend, 0);
		apb(1, ars_pkg::ADDR_CTRL, 32'h0);
		$display("test registers done");
		xmit <= 1'b1;
		cyc(16);
		chk("interlock", xil, 1);
		swr <= 2'b10;
		cyc(16);
		chk("arc", arc, 1);
		chk("arc interlock", xil, 0);
		swr <= 2'b00;
		cyc(16);
		chk("arc latched", arc, 1);
		apb(1, ars_pkg::ADDR_CTRL, 32'h2);
		cyc(1);
		chk("arc soft clear", arc, 0);
		swr <= 2'b01;
		cyc(16);
		chk("arc low band", arc, 1);
		swr <= 2'b00;
		arst <= 1'b1;
		cyc(16);
		arst <= 1'b0;
		cyc(16);
		chk("arc cleared", arc, 0);
		$display("test arc done");
		end_sim;
	end
	// Watchdog
	initial begin
		cyc(40000);
		mismatches++;
		end_sim;
	end
endmodule
`default_nettype wire
